// [verilog/aidiag_cfg.svh]
/*
 * constants of the analog input diagnostic status block: fault bit
 * positions, reset values, timing figures and byte indices.
 * assumes inclusion by bare name; definitions only.
 */
`ifndef AIDIAG_CFG_SVH
`define AIDIAG_CFG_SVH

// ============================================================
// fault byte layout
`define FAULT_PARAM_BIT      0
`define FAULT_IRQ_LOST_BIT   5
`define FAULT_UNDER_BIT      6
`define FAULT_OVER_BIT       7
`define FAULT_RESERVED_MASK  8'h1e
`define FAULT_BYTE_RESET     8'h00

// ============================================================
// timing
`define CLK_FREQ_HZ          10000000
`define TICK_PERIOD_NS       1000
`define CLK_PERIOD_NS        100
`define TICK_CYCLES          (`TICK_PERIOD_NS / `CLK_PERIOD_NS)
`define BLINK_FREQ_HZ        2
// half period of the blink, in clock cycles
`define BLINK_HALF_CYCLES    (`CLK_FREQ_HZ / (2 * `BLINK_FREQ_HZ))
`define TIMESTAMP_RESET      32'h0000_0000

// ============================================================
// diagnostic byte indices on the read port
`define IDX_CHANNEL_GROUP    4'h0
`define IDX_FAULT_FIRST      4'h1
`define IDX_SPARE_FIRST      4'h5
`define IDX_STAMP_FIRST      4'h9
`define IDX_LAST             4'hc

`endif

// [verilog/aidiag_pkg.sv]
/*
 * types of the analog input diagnostic status block.
 * assumes nothing of its surroundings.
 */
package aidiag_pkg;

    // mains frequency for interference suppression
    typedef enum logic [0:0] {
        mains_50hz = 1'b0,
        mains_60hz = 1'b1
    } mains_sel_type;

    // indicator state derived from bus and module health
    typedef enum logic [3:0] {
        ind_ok        = 4'b0001,
        ind_mod_error = 4'b0010,
        ind_no_comm   = 4'b0100,
        ind_no_power  = 4'b1000
    } ind_state_type;

endpackage

// [verilog/us_ticker.sv]
/*
 * free-running 32-bit microsecond ticker with a cycle prescaler.
 * assumes a 10 MHz clock; counts from zero after reset and wraps.
 */
`timescale 1ns/1ps
`include "aidiag_cfg.svh"

module us_ticker #(
    parameter int TICK_CYCLES = `TICK_CYCLES
) (
    input  wire logic        core_clk_in,
    input  wire logic        sys_rst_in,
    input  wire logic        clk_en_in,
    output logic      [31:0] ticks_out
);

    if (TICK_CYCLES < 1 || TICK_CYCLES > 255) begin : g_bad_tick
        $error("us_ticker: TICK_CYCLES out of range");
    end

    logic [7:0]  pre_reg;
    logic [7:0]  pre_next;
    logic [31:0] ticks_reg;
    logic [31:0] ticks_next;

    // ============================================================
    // prescaler and counter
    always_comb begin
        pre_next   = pre_reg;
        ticks_next = ticks_reg;
        if (clk_en_in) begin
            if (pre_reg == 8'(TICK_CYCLES - 1)) begin
                pre_next   = 8'h00;
                // wraps naturally to zero after the maximum
                ticks_next = ticks_reg + 32'h0000_0001;
            end else begin
                pre_next = pre_reg + 8'h01;
            end
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            pre_reg   <= 8'h00;
            ticks_reg <= `TIMESTAMP_RESET;
        end else begin
            pre_reg   <= pre_next;
            ticks_reg <= ticks_next;
        end
    end

    assign ticks_out = ticks_reg;

endmodule

// [verilog/blink_gen.sv]
/*
 * square wave for blinking an indicator.
 * assumes a 10 MHz clock; output toggles every half period.
 */
`timescale 1ns/1ps
`include "aidiag_cfg.svh"

module blink_gen #(
    parameter int HALF_CYCLES = `BLINK_HALF_CYCLES
) (
    input  wire logic core_clk_in,
    input  wire logic sys_rst_in,
    input  wire logic clk_en_in,
    output logic      blink_out
);

    if (HALF_CYCLES < 1 || HALF_CYCLES > (1 << 23)) begin : g_bad_half
        $error("blink_gen: HALF_CYCLES out of range");
    end

    logic [23:0] cnt_reg;
    logic [23:0] cnt_next;
    logic        wave_reg;
    logic        wave_next;

    // ============================================================
    // half period counter
    always_comb begin
        cnt_next  = cnt_reg;
        wave_next = wave_reg;
        if (clk_en_in) begin
            if (cnt_reg == 24'(HALF_CYCLES - 1)) begin
                cnt_next  = 24'h00_0000;
                wave_next = ~wave_reg;
            end else begin
                cnt_next = cnt_reg + 24'h00_0001;
            end
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            cnt_reg  <= 24'h00_0000;
            wave_reg <= 1'b0;
        end else begin
            cnt_reg  <= cnt_next;
            wave_reg <= wave_next;
        end
    end

    assign blink_out = wave_reg;

endmodule

// [verilog/analog_input_diag_status.sv]
/*
 * diagnostic status of a four-channel 0-10 V analog input module:
 * per-channel fault bytes, channel group summary, microsecond stamp of
 * the last diagnostic, run / module-fault / channel-fault indicators,
 * and a byte-wide read port for the diagnostic record.
 * assumes condition inputs come from asynchronous measuring logic and
 * are synchronised here; read index comes from logic on core_clk_in.
 */
// Contract
// - bit 0 of fault byte flags parameter error; bits 4..1 reserved.
// - bit 5 of fault byte flags a lost process interrupt.
// - bit 6 of fault byte flags signal below measuring range.
// - bit 7 of fault byte flags signal above measuring range.
// - on a diagnostic event the ticker value is latched as stamp.
// - microsecond ticker starts at zero on reset, counts each us.
// - ticker is 32 bits wide and wraps to zero then continues.
// - four channels, each with fault byte and fault indicator.
// - a parameter selects 50 Hz or 60 Hz interference suppression.
// - bus and module good: run lit, module fault dark.
// - bus good, module error: run and module fault both lit.
// - no bus communication: run dark, module fault lit.
// - bus power failed: run and module fault both dark.
// - configuration error blinks module fault at 2 Hz while bus power is good.
// - channel indicator lit when out of range or parameter error.
// - group summary bit set for each channel with any fault.
`timescale 1ns/1ps
`include "aidiag_cfg.svh"

module analog_input_diag_status #(
    parameter int                     NUM_CH     = 4,
    parameter int                     TICK_CYC   = `TICK_CYCLES,
    parameter int                     BLINK_HALF = `BLINK_HALF_CYCLES,
    parameter aidiag_pkg::mains_sel_type MAINS_SEL =
        aidiag_pkg::mains_50hz
) (
    input  wire logic                core_clk_in,
    input  wire logic                sys_rst_in,
    input  wire logic                clk_en_in,
    input  wire logic [NUM_CH-1:0]   param_err_in,
    input  wire logic [NUM_CH-1:0]   irq_lost_in,
    input  wire logic [NUM_CH-1:0]   under_range_in,
    input  wire logic [NUM_CH-1:0]   over_range_in,
    input  wire logic                bus_comm_ok_in,
    input  wire logic                bus_power_ok_in,
    input  wire logic                module_err_in,
    input  wire logic                config_err_in,
    input  wire logic [3:0]          diag_index_in,
    output logic      [7:0]          diag_byte_out,
    output logic      [7:0]          channel_group_summary_out,
    output logic      [31:0]         diag_event_timestamp_out,
    output logic                     mains_60hz_out,
    output logic                     run_led_out,
    output logic                     module_fault_led_out,
    output logic      [NUM_CH-1:0]   channel_fault_led_out
);

    if (NUM_CH != 4) begin : g_bad_ch
        $error("analog_input_diag_status: NUM_CH must be 4");
    end

    localparam int NCOND = 4 * NUM_CH + 4;

    // ============================================================
    // input synchronisers
    // every condition input crosses in from measuring or bus logic
    logic [NCOND-1:0] sync1_reg;
    logic [NCOND-1:0] sync1_next;
    logic [NCOND-1:0] sync2_reg;
    logic [NCOND-1:0] sync2_next;

    always_comb begin
        sync1_next = sync1_reg;
        sync2_next = sync2_reg;
        if (clk_en_in) begin
            sync1_next = {config_err_in, module_err_in, bus_power_ok_in,
                          bus_comm_ok_in, over_range_in, under_range_in,
                          irq_lost_in, param_err_in};
            sync2_next = sync1_reg;
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            sync1_reg <= '0;
            sync2_reg <= '0;
        end else begin
            sync1_reg <= sync1_next;
            sync2_reg <= sync2_next;
        end
    end

    logic [NUM_CH-1:0] param_s;
    logic [NUM_CH-1:0] irq_s;
    logic [NUM_CH-1:0] under_s;
    logic [NUM_CH-1:0] over_s;
    logic              comm_s;
    logic              power_s;
    logic              moderr_s;
    logic              cfgerr_s;

    assign param_s  = sync2_reg[NUM_CH-1:0];
    assign irq_s    = sync2_reg[2*NUM_CH-1:NUM_CH];
    assign under_s  = sync2_reg[3*NUM_CH-1:2*NUM_CH];
    assign over_s   = sync2_reg[4*NUM_CH-1:3*NUM_CH];
    assign comm_s   = sync2_reg[4*NUM_CH];
    assign power_s  = sync2_reg[4*NUM_CH+1];
    assign moderr_s = sync2_reg[4*NUM_CH+2];
    assign cfgerr_s = sync2_reg[4*NUM_CH+3];

    // ============================================================
    // per-channel fault bytes
    logic [7:0]        fault_reg  [NUM_CH];
    logic [7:0]        fault_next [NUM_CH];
    logic [NUM_CH-1:0] new_fault;
    logic [NUM_CH-1:0] any_fault;
    logic [NUM_CH-1:0] chan_led;

    for (genvar c = 0; c < NUM_CH; c++) begin : g_chan
        always_comb begin
            fault_next[c] = fault_reg[c];
            if (clk_en_in) begin
                // flags track their condition, no latching
                fault_next[c] = `FAULT_BYTE_RESET;
                fault_next[c][`FAULT_PARAM_BIT]    = param_s[c];
                fault_next[c][`FAULT_IRQ_LOST_BIT] = irq_s[c];
                fault_next[c][`FAULT_UNDER_BIT]    = under_s[c];
                fault_next[c][`FAULT_OVER_BIT]     = over_s[c];
            end
        end

        always_ff @(posedge core_clk_in) begin
            if (sys_rst_in)
                fault_reg[c] <= `FAULT_BYTE_RESET;
            else
                fault_reg[c] <= fault_next[c];
        end

        // a flag rising in a byte is a new diagnostic event
        assign new_fault[c] = |(fault_next[c] & ~fault_reg[c]);
        // next values, so the registered copies keep step with the bytes
        assign any_fault[c] = |fault_next[c];
        assign chan_led[c]  = fault_next[c][`FAULT_PARAM_BIT]
                            | fault_next[c][`FAULT_UNDER_BIT]
                            | fault_next[c][`FAULT_OVER_BIT];
    end

    // ============================================================
    // registered summary and channel indicators
    logic [NUM_CH-1:0] summary_reg;
    logic [NUM_CH-1:0] summary_next;
    logic [NUM_CH-1:0] chan_led_reg;
    logic [NUM_CH-1:0] chan_led_next;

    always_comb begin
        summary_next  = summary_reg;
        chan_led_next = chan_led_reg;
        if (clk_en_in) begin
            summary_next  = any_fault;
            chan_led_next = chan_led;
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            summary_reg  <= '0;
            chan_led_reg <= '0;
        end else begin
            summary_reg  <= summary_next;
            chan_led_reg <= chan_led_next;
        end
    end

    assign channel_fault_led_out = chan_led_reg;

    assign channel_group_summary_out =
        8'({{(8 - NUM_CH){1'b0}}, summary_reg});

    // ============================================================
    // ticker and event stamp
    logic [31:0] ticks;
    logic [31:0] stamp_reg;
    logic [31:0] stamp_next;

    us_ticker #(
        .TICK_CYCLES (TICK_CYC)
    ) u_ticker (
        .core_clk_in (core_clk_in),
        .sys_rst_in  (sys_rst_in),
        .clk_en_in   (clk_en_in),
        .ticks_out   (ticks)
    );

    always_comb begin
        stamp_next = stamp_reg;
        if (clk_en_in && (|new_fault))
            stamp_next = ticks;
    end

    always_ff @(posedge core_clk_in) begin
        if (sys_rst_in)
            stamp_reg <= `TIMESTAMP_RESET;
        else
            stamp_reg <= stamp_next;
    end

    assign diag_event_timestamp_out = stamp_reg;

    // ============================================================
    // indicators
    logic blink;

    blink_gen #(
        .HALF_CYCLES (BLINK_HALF)
    ) u_blink (
        .core_clk_in (core_clk_in),
        .sys_rst_in  (sys_rst_in),
        .clk_en_in   (clk_en_in),
        .blink_out   (blink)
    );

    aidiag_pkg::ind_state_type ind_state;
    logic run_next;
    logic mf_next;
    logic run_reg;
    logic mf_reg;

    always_comb begin
        if (!power_s)
            ind_state = aidiag_pkg::ind_no_power;
        else if (!comm_s)
            ind_state = aidiag_pkg::ind_no_comm;
        else if (moderr_s)
            ind_state = aidiag_pkg::ind_mod_error;
        else
            ind_state = aidiag_pkg::ind_ok;
        run_next = run_reg;
        mf_next  = mf_reg;
        if (clk_en_in) begin
            unique case (ind_state)
                aidiag_pkg::ind_ok: begin
                    run_next = 1'b1;
                    mf_next  = 1'b0;
                end
                aidiag_pkg::ind_mod_error: begin
                    run_next = 1'b1;
                    mf_next  = 1'b1;
                end
                aidiag_pkg::ind_no_comm: begin
                    run_next = 1'b0;
                    mf_next  = 1'b1;
                end
                aidiag_pkg::ind_no_power: begin
                    run_next = 1'b0;
                    mf_next  = 1'b0;
                end
            endcase
            // blink overrides only while powered; no power means dark
            if (cfgerr_s && power_s)
                mf_next = blink;
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            run_reg <= 1'b0;
            mf_reg  <= 1'b0;
        end else begin
            run_reg <= run_next;
            mf_reg  <= mf_next;
        end
    end

    assign run_led_out          = run_reg;
    assign module_fault_led_out = mf_reg;
    assign mains_60hz_out = (MAINS_SEL == aidiag_pkg::mains_60hz);

    // ============================================================
    // diagnostic record read port
    logic [7:0] rd_next;
    logic [7:0] rd_reg;
    logic [3:0] rel;

    always_comb begin
        rel     = diag_index_in - `IDX_FAULT_FIRST;
        rd_next = rd_reg;
        if (clk_en_in) begin
            rd_next = 8'h00;
            if (diag_index_in == `IDX_CHANNEL_GROUP)
                rd_next = channel_group_summary_out;
            else if (diag_index_in < `IDX_SPARE_FIRST)
                rd_next = fault_reg[rel[1:0]];
            else if (diag_index_in < `IDX_STAMP_FIRST)
                rd_next = 8'h00;
            else if (diag_index_in <= `IDX_LAST)
                // byte 0 of the stamp is its least significant byte
                rd_next = 8'(stamp_reg >> (8 * 32'(diag_index_in
                          - `IDX_STAMP_FIRST)));
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (sys_rst_in)
            rd_reg <= 8'h00;
        else
            rd_reg <= rd_next;
    end

    assign diag_byte_out = rd_reg;

endmodule

// [testbench/analog_input_diag_status_chk.sv]
/*
 * checker of the analog input diagnostic status block.
 * assumes it is bound to the top module and sees only its ports.
 */
`timescale 1ns/1ps

module analog_input_diag_status_chk #(
    parameter int NUM_CH     = 4,
    parameter int BLINK_HALF = 5
) (
    input  wire logic              core_clk_in,
    input  wire logic              sys_rst_in,
    input  wire logic [NUM_CH-1:0] param_err_in,
    input  wire logic [NUM_CH-1:0] irq_lost_in,
    input  wire logic [NUM_CH-1:0] under_range_in,
    input  wire logic [NUM_CH-1:0] over_range_in,
    input  wire logic              bus_comm_ok_in,
    input  wire logic              bus_power_ok_in,
    input  wire logic              module_err_in,
    input  wire logic              config_err_in,
    input  wire logic [7:0]        channel_group_summary_out,
    input  wire logic [31:0]       diag_event_timestamp_out,
    input  wire logic              run_led_out,
    input  wire logic              module_fault_led_out,
    input  wire logic [NUM_CH-1:0] channel_fault_led_out
);
    default clocking @(posedge core_clk_in); endclocking
    default disable iff (sys_rst_in);

    // ============================================================
    // helpers
    logic [2:0]            age_reg;
    logic [3:0]            cfg_cnt_reg;
    logic [3:0]            hold_reg;
    logic                  mf_q_reg;
    wire  [4*NUM_CH-1:0]   flags;
    wire  [3:0]            hv;
    assign flags = {param_err_in, irq_lost_in, under_range_in, over_range_in};
    assign hv = {bus_power_ok_in, bus_comm_ok_in, module_err_in, config_err_in};

    // age keeps every $past lookback clear of the reset span
    always_ff @(posedge core_clk_in) begin
        age_reg     <= sys_rst_in ? 3'h0 : age_reg + 3'(age_reg != 3'h7);
        cfg_cnt_reg <= (sys_rst_in || !(config_err_in && bus_power_ok_in)) ?
                       4'h0 : cfg_cnt_reg + 4'(cfg_cnt_reg != 4'hf);
        mf_q_reg    <= module_fault_led_out;
        hold_reg    <= (module_fault_led_out != mf_q_reg) ? 4'h0 :
                       hold_reg + 4'(hold_reg != 4'hf);
    end

    // ============================================================
    // properties
    property p_chan_led;
        age_reg > 3 |-> channel_fault_led_out == ($past(param_err_in, 3) |
            $past(under_range_in, 3) | $past(over_range_in, 3));
    endproperty
    a_chan_led: assert property (p_chan_led)
        else $error("channel led mismatch");

    property p_summary;
        age_reg > 3 |-> channel_group_summary_out == 8'($past(param_err_in |
            irq_lost_in | under_range_in | over_range_in, 3));
    endproperty
    a_summary: assert property (p_summary)
        else $error("group summary mismatch");

    property p_ok;
        age_reg > 5 && $past(hv, 3) == 4'hc && $past(hv, 4) == 4'hc
            |-> run_led_out && !module_fault_led_out;
    endproperty
    a_ok: assert property (p_ok)
        else $error("ok indication wrong");

    property p_mod_err;
        age_reg > 5 && $past(hv, 3) == 4'he && $past(hv, 4) == 4'he
            |-> run_led_out && module_fault_led_out;
    endproperty
    a_mod_err: assert property (p_mod_err)
        else $error("module error indication wrong");

    property p_no_comm;
        age_reg > 5 && $past(hv, 3) == 4'h8 && $past(hv, 4) == 4'h8
            |-> !run_led_out && module_fault_led_out;
    endproperty
    a_no_comm: assert property (p_no_comm)
        else $error("no comm indication wrong");

    property p_no_power;
        age_reg > 5 && !$past(hv[3], 3) && !$past(hv[3], 4)
            |-> !run_led_out && !module_fault_led_out;
    endproperty
    a_no_power: assert property (p_no_power)
        else $error("no power indication wrong");

    property p_blink;
        cfg_cnt_reg == 4'hf |-> hold_reg < BLINK_HALF &&
            (!$changed(module_fault_led_out) || hold_reg == BLINK_HALF - 1);
    endproperty
    a_blink: assert property (p_blink)
        else $error("module fault blink wrong");

    property p_stamp;
        age_reg > 4 && $changed(diag_event_timestamp_out)
            |-> |($past(flags, 3) & ~$past(flags, 4));
    endproperty
    a_stamp: assert property (p_stamp)
        else $error("stamp changed without event");
endmodule

bind analog_input_diag_status analog_input_diag_status_chk #(
    .NUM_CH(NUM_CH),
    .BLINK_HALF(BLINK_HALF)
) chk_u (
    .core_clk_in(core_clk_in),
    .sys_rst_in(sys_rst_in),
    .param_err_in(param_err_in),
    .irq_lost_in(irq_lost_in),
    .under_range_in(under_range_in),
    .over_range_in(over_range_in),
    .bus_comm_ok_in(bus_comm_ok_in),
    .bus_power_ok_in(bus_power_ok_in),
    .module_err_in(module_err_in),
    .config_err_in(config_err_in),
    .channel_group_summary_out(channel_group_summary_out),
    .diag_event_timestamp_out(diag_event_timestamp_out),
    .run_led_out(run_led_out),
    .module_fault_led_out(module_fault_led_out),
    .channel_fault_led_out(channel_fault_led_out)
);

// [testbench/bus_head_model.sv]
/*
 * model of the bus head reading the diagnostic record byte by byte.
 * assumes the read port answers one edge after the index is taken.
 */
`timescale 1ns/1ps

module bus_head_model (
    input  wire logic       clk_in,
    input  wire logic [7:0] byte_in,
    output logic      [3:0] index_out
);
    initial index_out = 4'h0;

    // ============================================================
    // index held two edges so the registered answer has settled
    task automatic read_idx(input logic [3:0] i, output logic [7:0] d);
        @(posedge clk_in) index_out <= i;
        @(posedge clk_in);
        @(posedge clk_in) d = byte_in;
    endtask
endmodule

// [testbench/test_analog_input_diag_status.sv]
/*
 * self-checking bench of the analog input diagnostic status block.
 * assumes shortened tick and blink counts set at the instance.
 */
`timescale 1ns/1ps

module test_analog_input_diag_status;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic [3:0]  pe = 4'h0, il = 4'h0, ur = 4'h0, orr = 4'h0;
    logic        comm = 1'b1, pwr = 1'b1, merr = 1'b0, cfg = 1'b0;
    logic        en = 1'b1;
    logic [3:0]  idx;
    logic [7:0]  dbyte, summ;
    logic [31:0] stamp;
    logic        m60, run, mf;
    logic [3:0]  led;
    int          mismatches = 0, tests_run = 0, cyc = 0;

    always #50 clk = ~clk;
    always @(posedge clk) cyc <= rst ? 0 : cyc + 1;

    analog_input_diag_status #(.TICK_CYC(2), .BLINK_HALF(5)) dut_u (
        .core_clk_in(clk), .sys_rst_in(rst), .clk_en_in(en),
        .param_err_in(pe), .irq_lost_in(il), .under_range_in(ur),
        .over_range_in(orr), .bus_comm_ok_in(comm),
        .bus_power_ok_in(pwr), .module_err_in(merr), .config_err_in(cfg),
        .diag_index_in(idx), .diag_byte_out(dbyte),
        .channel_group_summary_out(summ), .diag_event_timestamp_out(stamp),
        .mains_60hz_out(m60), .run_led_out(run),
        .module_fault_led_out(mf), .channel_fault_led_out(led));

    bus_head_model host_u (.clk_in(clk), .byte_in(dbyte), .index_out(idx));

    // ============================================================
    // shared tasks
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic end_sim();
        if (mismatches == 0 && tests_run > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // ============================================================
    // scenarios
    task automatic t_reset();
        logic [7:0] d;
        chk(stamp, 32'h0000_0000);
        chk(32'(m60), 32'h0);
        for (int i = 0; i < 14; i++) begin
            host_u.read_idx(4'(i), d);
            chk(32'(d), 32'h0);
        end
    endtask

    task automatic t_stamp();
        logic [7:0]  d;
        logic [31:0] s1, rd32;
        int          t0;
        @(posedge clk) orr[0] <= 1'b1;
        t0 = cyc;
        repeat (6) @(posedge clk);
        s1 = stamp;
        // ticker halves the cycle count with the prescaler of two
        chk(32'(s1 >= t0 / 2 && s1 <= t0 / 2 + 3), 32'h1);
        for (int b = 0; b < 4; b++) begin
            host_u.read_idx(4'(9 + b), d);
            rd32[8*b +: 8] = d;
        end
        chk(rd32, s1);
        @(posedge clk) orr[0] <= 1'b0;
        while (cyc < t0 + 40) @(posedge clk);
        chk(stamp, s1);
        orr[1] <= 1'b1;
        repeat (6) @(posedge clk);
        chk(stamp - s1, 32'd20);
        orr[1] <= 1'b0;
        repeat (5) @(posedge clk);
    endtask

    // inputs stay still while frozen, so the ticker alone shows the pause
    task automatic t_freeze();
        logic [31:0] s1;
        @(posedge clk) orr[2] <= 1'b1;
        repeat (6) @(posedge clk);
        s1 = stamp;
        orr[2] <= 1'b0;
        repeat (6) @(posedge clk);
        en <= 1'b0;
        repeat (20) @(posedge clk);
        en <= 1'b1;
        repeat (8) @(posedge clk);
        orr[3] <= 1'b1;
        repeat (6) @(posedge clk);
        // 40 edges apart, 20 of them frozen: 20 enabled edges, 10 ticks
        chk(stamp - s1, 32'd10);
        orr[3] <= 1'b0;
        repeat (5) @(posedge clk);
    endtask

    task automatic t_bits();
        logic [7:0] d;
        int         b;
        for (int c = 0; c < 4; c++) begin
            for (int k = 0; k < 4; k++) begin
                b = (k == 0) ? 0 : k + 4;
                @(posedge clk);
                pe[c]  <= (k == 0);
                il[c]  <= (k == 1);
                ur[c]  <= (k == 2);
                orr[c] <= (k == 3);
                repeat (5) @(posedge clk);
                host_u.read_idx(4'(1 + c), d);
                chk(32'(d), 32'(1 << b));
                chk(32'(summ), 32'(1 << c));
                chk(32'(led), (k == 1) ? 32'h0 : 32'(1 << c));
                host_u.read_idx(4'(5 + c), d);
                chk(32'(d), 32'h0);
                @(posedge clk) {pe, il, ur, orr} <= 16'h0;
                repeat (5) @(posedge clk);
                host_u.read_idx(4'(1 + c), d);
                chk(32'(d), 32'h0);
            end
        end
        @(posedge clk) {pe, il, ur, orr} <= 16'h8888;
        repeat (5) @(posedge clk);
        host_u.read_idx(4'h4, d);
        chk(32'(d), 32'he1);
        @(posedge clk) {pe, il, ur, orr} <= 16'h0;
        repeat (5) @(posedge clk);
    endtask

    task automatic t_leds();
        logic [2:0] in_t [4] = '{3'b110, 3'b111, 3'b100, 3'b000};
        logic [1:0] ex_t [4] = '{2'b10, 2'b11, 2'b01, 2'b00};
        logic       prev;
        int         n;
        for (int i = 0; i < 4; i++) begin
            @(posedge clk) {pwr, comm, merr} <= in_t[i];
            repeat (6) @(posedge clk);
            chk(32'({run, mf}), 32'(ex_t[i]));
        end
        @(posedge clk) {pwr, comm, merr, cfg} <= 4'b1101;
        repeat (10) @(posedge clk);
        n = 0;
        prev = mf;
        repeat (30) begin
            @(posedge clk);
            n += int'(mf !== prev);
            prev = mf;
        end
        chk(32'(n), 32'd6);
        @(posedge clk) pwr <= 1'b0;
        repeat (8) @(posedge clk);
        chk(32'({run, mf}), 32'h0);
        @(posedge clk) {pwr, cfg} <= 2'b10;
        repeat (8) @(posedge clk);
    endtask

    // ============================================================
    // main sequence and watchdog
    initial begin
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        t_reset();
        t_stamp();
        t_freeze();
        t_bits();
        t_leds();
        end_sim();
    end

    // all scenarios take well under 2,000 cycles
    initial begin
        #(5000 * 100);
        mismatches++;
        end_sim();
    end
endmodule
